// file: cpb_bridge.v
// core-to-peripheral register bridge: decode, strobes, stall timing, arbitration
// assumes one clock clk; peripheral logic samples strobes on per_en pulses and
// the buffer status and read data inputs are already on clk
//
// Functional notes
// - addresses 0x0 to 0x3FFFF are register space, split core and peripheral.
// - peripheral clock is exactly half the core clock.
// - peripheral writes go through a buffer that completes on its own.
// - isolated bridge write takes one core cycle from the core's view.
// - peripheral write terminates in 4 cycles on rising, 5 on falling phase.
// - a read right after a write returns the written value.
// - back to back writes stall one cycle each after the first.
// - writes on alternate cycles never stall.
// - peripheral reads take 7 or 8 cycles depending on phase.
// - reads never overlap; back to back read equals isolated read.
// - reads following a read align to the falling peripheral edge.
// - core-domain writes do not stall; core-domain reads take two cycles.
// - bridge decodes address into read and write strobes; core moves data.
// - conditional peripheral access costs 3 cycles write, 10 read.
// - aborted access costs 2/3 core domain, 4/4 peripheral domain.
// - write then read of one peripheral register takes 8 or 9; the read does not wait for the write.
// - full or empty buffer stalls the core unless buffer_hang_disable is set.
// - hold-off on a full transmit buffer adds one core cycle.
// - interrupted access after a write adds one stall cycle; an interrupted core-domain write is still taken at once, with no stall.
// - one bus at a time gets a register; core and transfer engine ports.
// - contention grants data bus, then program bus, then io buses.
//
// the write buffer holds a single entry; a new write that arrives while
// the entry still waits for its peripheral edge pushes the old entry out
// at once, so no write is ever lost, at the cost of an early strobe
//
// core_stall is combinational: the core sees the release in the last
// counted cycle and moves on at that same edge
`include "cpb_map.vh"

module cpb_bridge
(
    // clock and reset
    input  wire                      clk,
    input  wire                      reset,
    // core request
    input  wire                      core_req,
    input  wire                      core_we,
    input  wire [`CPB_ADDR_W-1:0]    core_addr,
    input  wire [`CPB_DATA_W-1:0]    core_wdata,
    input  wire                      core_cond,
    input  wire                      core_abort,
    input  wire                      core_intr,
    output wire                      core_stall,
    output reg  [`CPB_DATA_W-1:0]    core_rdata,
    output reg                       core_rvalid,
    // peripheral buffer status
    input  wire                      buf_full,
    input  wire                      buf_empty,
    input  wire                      buffer_hang_disable,
    // core-domain register strobes
    output reg                       creg_wr,
    output reg                       creg_rd,
    output reg  [`CPB_REGSEL_W-1:0]  creg_sel,
    input  wire [`CPB_DATA_W-1:0]    creg_rdata,
    // peripheral-domain register strobes
    output reg                       per_en,
    output reg                       per_wr,
    output reg                       per_rd,
    output reg  [`CPB_REGSEL_W-1:0]  per_sel,
    output reg  [`CPB_DATA_W-1:0]    per_wdata,
    input  wire [`CPB_DATA_W-1:0]    per_rdata,
    // bus arbitration per register
    input  wire                      data_mem_bus_req,
    input  wire                      program_mem_bus_req,
    input  wire                      io_bus_0_req,
    input  wire                      io_bus_1_req,
    output reg  [`CPB_GNT_W-1:0]     bus_grant
);

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    wire in_space  = (core_addr >= `CPB_REG_LO) && (core_addr <= `CPB_REG_HI);
    wire is_per    = in_space && (core_addr >= `CPB_PERIPH_BASE);
    wire is_core   = in_space && !is_per;
    wire [`CPB_REGSEL_W-1:0] sel =
        core_addr[`CPB_REGSEL_LSB+`CPB_REGSEL_W-1:`CPB_REGSEL_LSB];

    // ---------------------------------------------------------------
    // peripheral phase divider
    // ---------------------------------------------------------------
    reg phase_reg;
    always @(posedge clk)
    begin
        if (reset)
            phase_reg <= 1'b0;
        else
            phase_reg <= ~phase_reg;
    end
    // phase_reg low marks the rising half of the peripheral period
    wire rise_half = ~phase_reg;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    reg [`CPB_ST_W-1:0]  state_reg;
    reg [`CPB_CNT_W-1:0] cnt_reg;
    reg                  wbuf_busy_reg;
    reg [`CPB_CNT_W-1:0] wcnt_reg;
    reg [`CPB_REGSEL_W-1:0] wsel_reg;
    reg [`CPB_DATA_W-1:0]   wdata_reg;
    // high for one cycle after a write entered the buffer
    reg                  wfresh_reg;
    reg                  last_wr_reg;
    reg                  after_rd_reg;
    reg                  rd_per_reg;
    reg [`CPB_REGSEL_W-1:0] rsel_reg;

    wire idle = (state_reg == `CPB_ST_IDLE);

    // hang on full/empty buffer unless disabled
    wire hang = core_req && is_per && !buffer_hang_disable &&
                ((core_we && buf_full) || (!core_we && buf_empty));

    // a write one cycle behind the last buffered write stalls one cycle
    // a write on the alternate cycle is taken without a stall
    wire wr_collide = core_req && core_we && is_per && wbuf_busy_reg && wfresh_reg;

    // a full transmit buffer with hang disabled is held off, not taken
    wire held_off = core_req && core_we && is_per && buf_full && buffer_hang_disable;

    // a write that meets a free buffer is taken at once
    wire take_wr = idle && core_req && core_we && is_per && !hang && !wr_collide &&
                   !held_off && !core_abort && !core_cond && !core_intr;
    // core writes complete in one cycle
    wire take_cwr = idle && core_req && core_we && is_core && !core_abort;

    // a multi-cycle access releases the core in its last counted cycle
    wire finishing = !idle && (cnt_reg <= `CPB_ONE);

    // stall whenever a request is not finishing this cycle
    assign core_stall = hang || (!idle && !finishing) ||
                        (idle && core_req && in_space && !take_wr && !take_cwr);

    // ---------------------------------------------------------------
    // cost selection for multi-cycle accesses
    // ---------------------------------------------------------------
    reg [`CPB_CNT_W-1:0] cost;
    always @*
    begin
        cost = `CPB_ONE;
        if (core_abort)
            cost = is_per ? `CPB_ABT_PER : (core_we ? `CPB_ABT_CORE_WR : `CPB_ABT_CORE_RD);
        else if (core_cond && is_per)
            cost = core_we ? `CPB_COND_WR : `CPB_COND_RD;
        else if (!core_we && is_per)
            // phase sets read length, reads after a read use falling
            cost = (rise_half && !after_rd_reg) ? `CPB_RD_RISE : `CPB_RD_FALL;
        else if (!core_we)
            cost = `CPB_CORE_RD;
        else if (wr_collide)
            cost = `CPB_ONE + `CPB_ONE;
        // held-off transmit access pays one more
        if (core_we && is_per && buf_full && buffer_hang_disable)
            cost = cost + `CPB_ONE;
        // interrupted access after a write pays one more
        if (core_intr && last_wr_reg)
            cost = cost + `CPB_ONE;
    end

    // ---------------------------------------------------------------
    // main sequencer
    // ---------------------------------------------------------------
    always @(posedge clk)
    begin
        if (reset)
        begin
            state_reg    <= `CPB_ST_IDLE;
            cnt_reg      <= {`CPB_CNT_W{1'b0}};
            last_wr_reg  <= 1'b0;
            after_rd_reg <= 1'b0;
            rd_per_reg   <= 1'b0;
            rsel_reg     <= {`CPB_REGSEL_W{1'b0}};
            core_rdata   <= {`CPB_DATA_W{1'b0}};
            core_rvalid  <= 1'b0;
        end
        else
        begin
            core_rvalid <= 1'b0;
            case (state_reg)
                `CPB_ST_IDLE:
                begin
                    if (core_req && in_space && !hang)
                    begin
                        last_wr_reg <= core_we;
                        if (!take_wr && !take_cwr)
                        begin
                            // one access in flight at a time
                            cnt_reg    <= cost - `CPB_ONE;
                            rd_per_reg <= is_per && !core_we && !core_abort;
                            rsel_reg   <= sel;
                            if (!core_we && !core_abort)
                                state_reg <= is_per ? `CPB_ST_PRD : `CPB_ST_CRD;
                            else
                                state_reg <= `CPB_ST_HOLD;
                        end
                    end
                    if (!core_req)
                        after_rd_reg <= 1'b0;
                end
                `CPB_ST_HOLD, `CPB_ST_CRD, `CPB_ST_PRD:
                begin
                    if (cnt_reg <= `CPB_ONE)
                    begin
                        state_reg <= `CPB_ST_IDLE;
                        if (state_reg != `CPB_ST_HOLD)
                        begin
                            // data returns as the stall drops
                            core_rdata   <= rd_per_reg ? per_rdata : creg_rdata;
                            core_rvalid  <= 1'b1;
                            after_rd_reg <= rd_per_reg;
                        end
                    end
                    cnt_reg <= cnt_reg - `CPB_ONE;
                end
                default:
                    state_reg <= `CPB_ST_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // write buffer and strobes
    // ---------------------------------------------------------------
    wire per_wr_go = take_wr || (state_reg == `CPB_ST_HOLD && cnt_reg <= `CPB_ONE &&
                                 !core_abort && core_we && is_per);
    always @(posedge clk)
    begin
        if (reset)
        begin
            wbuf_busy_reg <= 1'b0;
            wfresh_reg    <= 1'b0;
            wcnt_reg      <= {`CPB_CNT_W{1'b0}};
            wsel_reg      <= {`CPB_REGSEL_W{1'b0}};
            wdata_reg     <= {`CPB_DATA_W{1'b0}};
            per_en        <= 1'b0;
            per_wr        <= 1'b0;
            per_rd        <= 1'b0;
            per_sel       <= {`CPB_REGSEL_W{1'b0}};
            per_wdata     <= {`CPB_DATA_W{1'b0}};
            creg_wr       <= 1'b0;
            creg_rd       <= 1'b0;
            creg_sel      <= {`CPB_REGSEL_W{1'b0}};
        end
        else
        begin
            per_en  <= rise_half;
            per_wr  <= 1'b0;
            per_rd  <= 1'b0;
            creg_wr <= 1'b0;
            creg_rd <= 1'b0;
            wfresh_reg <= per_wr_go;
            if (per_wr_go)
            begin
                // a pending entry is pushed out before it is replaced
                if (wbuf_busy_reg)
                begin
                    per_wr    <= 1'b1;
                    per_sel   <= wsel_reg;
                    per_wdata <= wdata_reg;
                end
                // buffered write, 4 or 5 cycles by phase
                wbuf_busy_reg <= 1'b1;
                wcnt_reg      <= rise_half ? `CPB_WR_RISE : `CPB_WR_FALL;
                wsel_reg      <= sel;
                wdata_reg     <= core_wdata;
            end
            else if (wbuf_busy_reg)
            begin
                wcnt_reg <= wcnt_reg - `CPB_ONE;
                // strobe lands on a peripheral edge
                if (wcnt_reg == `CPB_ONE + `CPB_ONE)
                begin
                    per_wr    <= 1'b1;
                    per_sel   <= wsel_reg;
                    per_wdata <= wdata_reg;
                end
                if (wcnt_reg == `CPB_ONE)
                    wbuf_busy_reg <= 1'b0;
            end
            // read strobe issues only once the buffer has drained
            // two cycles before the end any earlier write has landed,
            // since the longest write is shorter than the shortest read
            if (state_reg == `CPB_ST_PRD && cnt_reg == `CPB_ONE + `CPB_ONE &&
                !wbuf_busy_reg)
            begin
                per_rd  <= 1'b1;
                per_sel <= rsel_reg;
            end
            if (take_cwr)
            begin
                creg_wr  <= 1'b1;
                creg_sel <= sel;
            end
            if (idle && core_req && !core_we && is_core && !core_abort)
            begin
                creg_rd  <= 1'b1;
                creg_sel <= sel;
            end
        end
    end

    // ---------------------------------------------------------------
    // register arbitration
    // ---------------------------------------------------------------
    // one grant, fixed priority
    // a lower bus waits as long as a higher one keeps asking; the
    // requesters are expected to release between transfers
    always @(posedge clk)
    begin
        if (reset)
            bus_grant <= {`CPB_GNT_W{1'b0}};
        else if (data_mem_bus_req)
            bus_grant <= `CPB_GNT_DM;
        else if (program_mem_bus_req)
            bus_grant <= `CPB_GNT_PM;
        else if (io_bus_0_req)
            bus_grant <= `CPB_GNT_IO0;
        else if (io_bus_1_req)
            bus_grant <= `CPB_GNT_IO1;
        else
            bus_grant <= {`CPB_GNT_W{1'b0}};
    end

endmodule

// file: cpb_map.vh
// address map, timing counts and state codes for the core-to-peripheral bridge
// assumes a single 100 MHz core clock; peripheral rate is an enable pulse
`ifndef CPB_MAP_VH
`define CPB_MAP_VH

// ---------------------------------------------------------------
// register space
// ---------------------------------------------------------------
`define CPB_ADDR_W        32
`define CPB_DATA_W        32
`define CPB_REG_LO        32'h00000000
`define CPB_REG_HI        32'h0003FFFF
// addresses at or above this split point are peripheral-clock registers
`define CPB_PERIPH_BASE   32'h00030000
`define CPB_REGSEL_W      16
`define CPB_REGSEL_LSB    2

// ---------------------------------------------------------------
// cycle counts in core cycles
// ---------------------------------------------------------------
`define CPB_CNT_W         4
`define CPB_WR_RISE       4'h4
`define CPB_WR_FALL       4'h5
`define CPB_RD_RISE       4'h7
`define CPB_RD_FALL       4'h8
`define CPB_CORE_RD       4'h2
`define CPB_COND_WR       4'h3
`define CPB_COND_RD       4'hA
`define CPB_ABT_CORE_WR   4'h2
`define CPB_ABT_CORE_RD   4'h3
`define CPB_ABT_PER       4'h4
`define CPB_ONE           4'h1

// ---------------------------------------------------------------
// state codes, one-hot
// ---------------------------------------------------------------
`define CPB_ST_W          4
`define CPB_ST_IDLE       4'h1
`define CPB_ST_HOLD       4'h2
`define CPB_ST_PRD        4'h4
`define CPB_ST_CRD        4'h8

// ---------------------------------------------------------------
// grant codes
// ---------------------------------------------------------------
`define CPB_GNT_W         4
`define CPB_GNT_DM        4'h1
`define CPB_GNT_PM        4'h2
`define CPB_GNT_IO0       4'h4
`define CPB_GNT_IO1       4'h8

`endif

// file: cpb_reg_model.sv
// register files on the far side of the bridge, both clock domains
// assumes strobes arrive on clk, peripheral write data lands at once
module cpb_reg_model
(
    // clock
    input  wire logic        clk,
    // peripheral registers
    input  wire logic        per_wr,
    input  wire logic [15:0] per_sel,
    input  wire logic [31:0] per_wdata,
    output wire logic [31:0] per_rdata,
    // core registers
    input  wire logic [15:0] creg_sel,
    output wire logic [31:0] creg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem_reg [0:15];
    always @(posedge clk)
        if (per_wr)
            mem_reg[per_sel[3:0]] <= per_wdata;
    assign per_rdata  = mem_reg[per_sel[3:0]];
    // core file echoes the select so decode errors show
    assign creg_rdata = {16'hC0DE, creg_sel};
endmodule

// file: cpb_properties.sv
// timing and arbitration properties at the bridge ports
// assumes one clock, reset synchronous and active high
`include "cpb_map.vh"
module cpb_props
(
    input wire                   clk,
    input wire                   reset,
    input wire                   core_req,
    input wire                   core_we,
    input wire [`CPB_ADDR_W-1:0] core_addr,
    input wire                   core_cond,
    input wire                   core_abort,
    input wire                   core_intr,
    input wire                   core_stall,
    input wire                   buf_full,
    input wire                   buf_empty,
    input wire                   buffer_hang_disable,
    input wire                   creg_wr,
    input wire                   per_en,
    input wire                   per_wr,
    input wire                   per_rd,
    input wire                   data_mem_bus_req,
    input wire [`CPB_GNT_W-1:0]  bus_grant
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    reg  stall_reg;
    wire is_per = core_addr >= `CPB_PERIPH_BASE && core_addr <= `CPB_REG_HI;
    wire plain  = !core_cond && !core_abort && !core_intr && !stall_reg;
    always @(posedge clk)
        stall_reg <= core_stall;
    chk_grant_onehot: assert property ($onehot0(bus_grant))
        else $error("grant not one-hot");
    chk_grant_order: assert property (bus_grant == `CPB_GNT_PM |-> !$past(data_mem_bus_req))
        else $error("program bus granted over data bus");
    chk_per_en_fall: assert property (per_en |=> !per_en)
        else $error("peripheral enable high twice");
    chk_per_en_rise: assert property ($fell(per_en) |=> per_en)
        else $error("peripheral enable low twice");
    chk_strobe_excl: assert property (!(per_wr && per_rd))
        else $error("read and write strobes together");
    chk_core_wr_free: assert property (core_req && core_we && plain && core_addr < `CPB_PERIPH_BASE
        |-> !core_stall)
        else $error("core register write stalled");
    chk_hang_full: assert property (core_req && core_we && is_per && buf_full && !buffer_hang_disable
        |-> core_stall)
        else $error("write to full buffer not held");
    chk_out_range: assert property (core_req && core_addr > `CPB_REG_HI
        |-> !core_stall ##1 (!creg_wr && !per_wr))
        else $error("access outside register space acted on");
    chk_per_rd_time: assert property (core_req && !core_we && is_per && plain && !buf_empty
        |-> core_stall [*6] ##[1:2] !core_stall)
        else $error("peripheral read length wrong");
    chk_cond_wr_time: assert property (core_req && core_we && is_per && core_cond && !core_abort
        && !stall_reg && !buf_full |-> core_stall [*2] ##1 !core_stall)
        else $error("conditional write length wrong");
endmodule
bind cpb_bridge cpb_props cpb_props_i (.clk(clk), .reset(reset), .core_req(core_req),
    .core_we(core_we), .core_addr(core_addr), .core_cond(core_cond), .core_abort(core_abort),
    .core_intr(core_intr), .core_stall(core_stall), .buf_full(buf_full), .buf_empty(buf_empty),
    .buffer_hang_disable(buffer_hang_disable), .creg_wr(creg_wr), .per_en(per_en),
    .per_wr(per_wr), .per_rd(per_rd), .data_mem_bus_req(data_mem_bus_req), .bus_grant(bus_grant));

// file: tb_top.sv
// self-checking bench for the core-to-peripheral bridge
// assumes the register model answers both register files
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, reset = 1'b1, core_req = 1'b0, core_we = 1'b0;
    logic core_cond = 1'b0, core_abort = 1'b0, core_intr = 1'b0;
    logic buf_full = 1'b0, buf_empty = 1'b0, hang_dis = 1'b0;
    logic [31:0] core_addr = 32'h0, core_wdata = 32'h0, core_rdata, creg_rdata, per_rdata, per_wdata;
    logic [3:0] reqs = 4'h0, bus_grant;
    logic [15:0] creg_sel, per_sel;
    logic core_stall, core_rvalid, creg_wr, creg_rd, per_en, per_wr, per_rd;
    int mismatches = 0, n_compared = 0, n;
    logic [31:0] rd;
    cpb_bridge cpb_bridge_i (.clk(clk), .reset(reset), .core_req(core_req), .core_we(core_we),
        .core_addr(core_addr), .core_wdata(core_wdata), .core_cond(core_cond), .core_abort(core_abort),
        .core_intr(core_intr), .core_stall(core_stall), .core_rdata(core_rdata), .core_rvalid(core_rvalid),
        .buf_full(buf_full), .buf_empty(buf_empty), .buffer_hang_disable(hang_dis), .creg_wr(creg_wr),
        .creg_rd(creg_rd), .creg_sel(creg_sel), .creg_rdata(creg_rdata), .per_en(per_en), .per_wr(per_wr),
        .per_rd(per_rd), .per_sel(per_sel), .per_wdata(per_wdata), .per_rdata(per_rdata),
        .data_mem_bus_req(reqs[0]), .program_mem_bus_req(reqs[1]), .io_bus_0_req(reqs[2]),
        .io_bus_1_req(reqs[3]), .bus_grant(bus_grant));
    cpb_reg_model cpb_reg_model_i (.clk(clk), .per_wr(per_wr), .per_sel(per_sel), .per_wdata(per_wdata),
        .per_rdata(per_rdata), .creg_sel(creg_sel), .creg_rdata(creg_rdata));
    initial
    begin
        forever #5 clk = ~clk;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // m is {abort, cond}; entered and left at a rising edge, n counts edges to acceptance
    // one 32-bit word per access, no paired or long-word transfers
    task acc(input logic we, input logic [31:0] a, input logic [31:0] d, input logic [1:0] m);
        core_req <= 1'b1;
        core_we <= we;
        core_addr <= a;
        core_wdata <= d;
        {core_abort, core_cond} <= m;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (core_stall === 1'b1 && n < 40);
    endtask
    task idle();
        core_req <= 1'b0;
        @(posedge clk);
    endtask
    task get_rd();
        core_req <= 1'b0;
        for (int k = 0; k < 12 && core_rvalid !== 1'b1; k++)
            @(posedge clk);
        rd = core_rdata;
    endtask
    task t_core();
        acc(1'b1, 32'h100, 32'h5, 2'b00);
        chk(n, 1);
        acc(1'b0, 32'h100, 32'h0, 2'b00);
        chk(n, 2);
        get_rd();
        chk(rd, {16'hC0DE, 16'h0040});
        acc(1'b1, 32'h40000, 32'h1, 2'b00);
        chk(n, 1);
        idle();
        $display("core register test done");
    endtask
    task t_per();
        acc(1'b1, 32'h30010, 32'hA5A5F00F, 2'b00);
        chk(n, 1);
        acc(1'b1, 32'h30014, 32'h12345678, 2'b00);
        chk(n, 2);
        idle();
        acc(1'b1, 32'h30018, 32'h0000BEEF, 2'b00);
        chk(n, 1);
        acc(1'b0, 32'h30018, 32'h0, 2'b00);
        chk(n == 7 || n == 8, 1);
        // check the last read's data, then read the first written register back to back
        core_addr <= 32'h30010;
        @(posedge clk);
        rd = core_rdata;
        chk(rd, 32'h0000BEEF);
        n = 1;
        while (core_stall === 1'b1 && n < 40)
        begin
            @(posedge clk);
            n++;
        end
        chk(n, 8);
        get_rd();
        chk(rd, 32'hA5A5F00F);
        idle();
        $display("peripheral access test done");
    endtask
    task t_cost();
        logic [32:0] tab [6] = '{{1'b1, 32'h30020}, {1'b0, 32'h30020}, {1'b1, 32'h200},
            {1'b0, 32'h200}, {1'b1, 32'h30024}, {1'b0, 32'h30024}};
        int exp [6] = '{3, 10, 2, 3, 4, 4};
        for (int i = 0; i < 6; i++)
        begin
            acc(tab[i][32], tab[i][31:0], 32'h7, i < 2 ? 2'b01 : 2'b10);
            idle();
            chk(n, exp[i]);
        end
        $display("conditional and abort test done");
    endtask
    task t_hang();
        buf_full <= 1'b1;
        hang_dis <= 1'b1;
        acc(1'b1, 32'h30030, 32'h9, 2'b00);
        chk(n, 2);
        idle();
        hang_dis <= 1'b0;
        acc(1'b1, 32'h30030, 32'h9, 2'b00);
        chk(n, 40);
        buf_full <= 1'b0;
        acc(1'b1, 32'h30030, 32'h9, 2'b00);
        chk(n < 3, 1);
        idle();
        $display("buffer hang test done");
    endtask
    task t_arb();
        for (int i = 0; i < 4; i++)
        begin
            reqs <= 4'hF << i;
            repeat (3) @(posedge clk);
            chk(bus_grant, 4'h1 << i);
        end
        reqs <= 4'h0;
        @(posedge clk);
        $display("arbitration test done");
    endtask
    task print_verdict();
        $display("compared %0d, mismatched %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        #20000;
        mismatches++;
        print_verdict();
    end
    initial
    begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_core();
        t_per();
        t_cost();
        t_hang();
        t_arb();
        print_verdict();
    end
endmodule
